// [core/crcfc_device.sv]
`timescale 1ns/10ps
module crcfc_device (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Special function register bus
    crcfc_sfr_if.dev SFR,
    // Code memory fetch port, data one cycle after the read
    output logic [15:0] CODE_ADDR,
    output logic CODE_RD,
    input wire logic [7:0] CODE_DATA
);

    function automatic logic [15:0] crc_fold(
        input logic [15:0] acc,
        input logic [7:0] din
    );
        logic [15:0] c;
        c = acc ^ {din, crcfc_pkg::BYTE_RESET};
        for (int i = 0; i < crcfc_pkg::BITS_PER_BYTE; i++) begin
            if (c[15]) begin
                c = {c[14:0], 1'b0} ^ crcfc_pkg::CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc_fold

    crcfc_pkg::crcfc_state_t state_reg;
    crcfc_pkg::crcfc_state_t state_next;
    logic [15:0] acc_reg;
    logic [15:0] acc_next;
    logic seed_select_reg;
    logic result_byte_pointer_reg;
    logic result_byte_pointer_next;
    logic auto_mode_enable_reg;
    logic [7:0] auto_start_block_reg;
    logic [7:0] auto_block_count_reg;
    logic [7:0] bit_reverse_reg;
    logic [7:0] data_in_reg;
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic [15:0] left_reg;
    logic [15:0] left_next;
    logic code_rd_reg;
    logic hold_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] reversed_wdata;

    // Bus access is shut out while the engine runs; the core is stalled then
    wire busy = (state_reg != crcfc_pkg::ST_IDLE);
    wire wr_ok = SFR.wr && !busy;
    wire rd_ok = SFR.rd && !busy;
    wire wr_ctrl = wr_ok && (SFR.addr == crcfc_pkg::ADDR_CTRL);
    wire wr_auto = wr_ok && (SFR.addr == crcfc_pkg::ADDR_AUTO_CTRL);
    wire wr_flip = wr_ok && (SFR.addr == crcfc_pkg::ADDR_BIT_REVERSE);
    wire wr_start = wr_ok && (SFR.addr == crcfc_pkg::ADDR_START_BLOCK);
    wire wr_count = wr_ok && (SFR.addr == crcfc_pkg::ADDR_BLOCK_COUNT);
    wire wr_din = wr_ok && (SFR.addr == crcfc_pkg::ADDR_DATA_IN);
    wire wr_res = wr_ok && (SFR.addr == crcfc_pkg::ADDR_RESULT);
    wire rd_res = rd_ok && (SFR.addr == crcfc_pkg::ADDR_RESULT);
    wire seed_load = wr_ctrl && SFR.wdata[crcfc_pkg::CTRL_SEED_LOAD_BIT];
    wire seed_pick = SFR.wdata[crcfc_pkg::CTRL_SEED_SELECT_BIT];
    wire launch = wr_ctrl && auto_mode_enable_reg;
    // A zero block count launches nothing and leaves the done flag high
    wire launch_run = launch && (auto_block_count_reg != crcfc_pkg::BYTE_RESET);
    wire last_byte = (left_reg == crcfc_pkg::LAST_BYTE_LEFT);
    wire [15:0] seed_value = seed_pick ? crcfc_pkg::SEED_ALL_ONE
                                       : crcfc_pkg::SEED_ALL_ZERO;
    wire [7:0] result_sel = result_byte_pointer_reg ? acc_reg[15:8]
                                                    : acc_reg[7:0];
    wire [7:0] ctrl_read = crcfc_pkg::CTRL_RESERVED_VALUE
        | {5'h00, seed_select_reg, 1'b0, result_byte_pointer_reg};
    wire [7:0] auto_read = {auto_mode_enable_reg, !busy, 6'h00};

    always_comb begin
        for (int i = 0; i < crcfc_pkg::BITS_PER_BYTE; i++) begin
            reversed_wdata[i] = SFR.wdata[crcfc_pkg::BITS_PER_BYTE - 1 - i];
        end
    end

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        left_next = left_reg;
        case (state_reg)
            crcfc_pkg::ST_IDLE: begin
                if (launch_run) begin
                    state_next = crcfc_pkg::ST_FETCH;
                    addr_next = {auto_start_block_reg,
                                 crcfc_pkg::BLOCK_OFFSET_ZERO};
                    left_next = {auto_block_count_reg,
                                 crcfc_pkg::BLOCK_OFFSET_ZERO};
                end
            end
            crcfc_pkg::ST_FETCH: begin
                state_next = crcfc_pkg::ST_FOLD;
            end
            crcfc_pkg::ST_FOLD: begin
                addr_next = addr_reg + 16'h0001;
                left_next = left_reg - 16'h0001;
                if (last_byte) begin
                    state_next = crcfc_pkg::ST_IDLE;
                end else begin
                    state_next = crcfc_pkg::ST_FETCH;
                end
            end
            default: begin
                state_next = crcfc_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        acc_next = acc_reg;
        if (state_reg == crcfc_pkg::ST_FOLD) begin
            acc_next = crc_fold(acc_reg, CODE_DATA);
        end else if (seed_load) begin
            acc_next = seed_value;
        end else if (wr_din) begin
            acc_next = crc_fold(acc_reg, SFR.wdata);
        end else if (wr_res && result_byte_pointer_reg) begin
            acc_next = {SFR.wdata, acc_reg[7:0]};
        end else if (wr_res) begin
            acc_next = {acc_reg[15:8], SFR.wdata};
        end
    end

    always_comb begin
        result_byte_pointer_next = result_byte_pointer_reg;
        if (wr_ctrl) begin
            result_byte_pointer_next = SFR.wdata[crcfc_pkg::CTRL_POINTER_BIT];
        end else if (rd_res) begin
            result_byte_pointer_next = !result_byte_pointer_reg;
        end
    end

    // Unmapped addresses read as zero
    always_comb begin
        rdata_next = crcfc_pkg::BYTE_RESET;
        if (!rd_ok) begin
            rdata_next = crcfc_pkg::BYTE_RESET;
        end else if (SFR.addr == crcfc_pkg::ADDR_CTRL) begin
            rdata_next = ctrl_read;
        end else if (SFR.addr == crcfc_pkg::ADDR_AUTO_CTRL) begin
            rdata_next = auto_read;
        end else if (SFR.addr == crcfc_pkg::ADDR_BIT_REVERSE) begin
            rdata_next = bit_reverse_reg;
        end else if (SFR.addr == crcfc_pkg::ADDR_START_BLOCK) begin
            rdata_next = auto_start_block_reg;
        end else if (SFR.addr == crcfc_pkg::ADDR_BLOCK_COUNT) begin
            rdata_next = auto_block_count_reg;
        end else if (SFR.addr == crcfc_pkg::ADDR_DATA_IN) begin
            rdata_next = data_in_reg;
        end else if (SFR.addr == crcfc_pkg::ADDR_RESULT) begin
            rdata_next = result_sel;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_reg <= crcfc_pkg::ST_IDLE;
            acc_reg <= crcfc_pkg::WORD_RESET;
            addr_reg <= crcfc_pkg::WORD_RESET;
            left_reg <= crcfc_pkg::WORD_RESET;
            result_byte_pointer_reg <= 1'b0;
            code_rd_reg <= 1'b0;
            hold_reg <= 1'b0;
            rdata_reg <= crcfc_pkg::BYTE_RESET;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            addr_reg <= addr_next;
            left_reg <= left_next;
            result_byte_pointer_reg <= result_byte_pointer_next;
            code_rd_reg <= (state_next == crcfc_pkg::ST_FETCH);
            hold_reg <= (state_next != crcfc_pkg::ST_IDLE);
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            seed_select_reg <= 1'b0;
            auto_mode_enable_reg <= 1'b0;
            auto_start_block_reg <= crcfc_pkg::BYTE_RESET;
            auto_block_count_reg <= crcfc_pkg::BYTE_RESET;
            bit_reverse_reg <= crcfc_pkg::BYTE_RESET;
            data_in_reg <= crcfc_pkg::BYTE_RESET;
        end else begin
            if (wr_ctrl) begin
                seed_select_reg <= seed_pick;
            end
            if (wr_auto) begin
                auto_mode_enable_reg <= SFR.wdata[crcfc_pkg::AUTO_ENABLE_BIT];
            end
            if (wr_start) begin
                auto_start_block_reg <= SFR.wdata;
            end
            if (wr_count) begin
                auto_block_count_reg <= SFR.wdata;
            end
            if (wr_flip) begin
                bit_reverse_reg <= reversed_wdata;
            end
            if (wr_din) begin
                data_in_reg <= SFR.wdata;
            end
        end
    end

    assign SFR.rdata = rdata_reg;
    assign SFR.hold = hold_reg;
    assign CODE_ADDR = addr_reg;
    assign CODE_RD = code_rd_reg;

endmodule : crcfc_device

// [core/crcfc_pkg.sv]
package crcfc_pkg;
    // Register addresses on the special function register bus
    localparam logic [7:0] ADDR_AUTO_CTRL = 8'h86;
    localparam logic [7:0] ADDR_CTRL = 8'hce;
    localparam logic [7:0] ADDR_BIT_REVERSE = 8'hcf;
    localparam logic [7:0] ADDR_START_BLOCK = 8'hd2;
    localparam logic [7:0] ADDR_BLOCK_COUNT = 8'hd3;
    localparam logic [7:0] ADDR_DATA_IN = 8'hdd;
    localparam logic [7:0] ADDR_RESULT = 8'hde;

    // crc_control fields
    localparam int CTRL_SEED_LOAD_BIT = 3;
    localparam int CTRL_SEED_SELECT_BIT = 2;
    localparam int CTRL_POINTER_BIT = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h0d;
    localparam logic [7:0] CTRL_RESERVED_VALUE = 8'h10;

    // crc_auto_control fields
    localparam int AUTO_ENABLE_BIT = 7;
    localparam int AUTO_DONE_BIT = 6;
    localparam logic [7:0] AUTO_WRITE_MASK = 8'h80;

    // Checksum arithmetic
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] SEED_ALL_ZERO = 16'h0000;
    localparam logic [15:0] SEED_ALL_ONE = 16'hffff;
    localparam int BITS_PER_BYTE = 8;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Block size is 256 bytes: block number forms the address high byte
    localparam logic [7:0] BLOCK_OFFSET_ZERO = 8'h00;
    localparam logic [15:0] LAST_BYTE_LEFT = 16'h0001;

    // Cycles after a launching write that the core must keep harmless
    localparam logic [1:0] LAUNCH_GUARD_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_FOLD = 2'b10
    } crcfc_state_t;
endpackage : crcfc_pkg

// [core/crcfc_sfr_if.sv]
`timescale 1ns/10ps
interface crcfc_sfr_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic hold;

    modport dev (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        output hold
    );

    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        input hold
    );
endinterface : crcfc_sfr_if

// [core/crcfc_host.sv]
`timescale 1ns/10ps
module crcfc_host (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Software command port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic RD_VALID,
    output logic STALL,
    // Special function register bus
    crcfc_sfr_if.host SFR
);

    logic [7:0] addr_reg;
    logic [7:0] wdata_reg;
    logic wr_reg;
    logic rd_reg;
    logic rd_wait_reg;
    logic [7:0] rdata_reg;
    logic rd_valid_reg;
    logic stall_reg;
    logic auto_shadow_reg;
    logic [1:0] guard_reg;
    logic [1:0] guard_next;

    // Requests are dropped while stalled: the core executes nothing then
    wire take_wr = WR && !stall_reg;
    wire take_rd = RD && !stall_reg && !WR;
    wire to_ctrl = (ADDR == crcfc_pkg::ADDR_CTRL);
    wire to_auto = (ADDR == crcfc_pkg::ADDR_AUTO_CTRL);
    wire launching = take_wr && to_ctrl && auto_shadow_reg;
    // Reserved bits are always written with their reset value
    wire [7:0] ctrl_wdata = (WDATA & crcfc_pkg::CTRL_WRITE_MASK)
                            | crcfc_pkg::CTRL_RESERVED_VALUE;
    wire [7:0] auto_wdata = WDATA & crcfc_pkg::AUTO_WRITE_MASK;
    wire [7:0] bus_wdata = to_ctrl ? ctrl_wdata
                         : (to_auto ? auto_wdata : WDATA);

    // Guard spans the cycles before the device hold is seen
    always_comb begin
        guard_next = guard_reg;
        if (launching) begin
            guard_next = crcfc_pkg::LAUNCH_GUARD_CYCLES;
        end else if (guard_reg != 2'h0) begin
            guard_next = guard_reg - 2'h1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            addr_reg <= crcfc_pkg::BYTE_RESET;
            wdata_reg <= crcfc_pkg::BYTE_RESET;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            rdata_reg <= crcfc_pkg::BYTE_RESET;
            rd_valid_reg <= 1'b0;
            stall_reg <= 1'b0;
            auto_shadow_reg <= 1'b0;
            guard_reg <= 2'h0;
        end else begin
            if (take_wr || take_rd) begin
                addr_reg <= ADDR;
            end
            if (take_wr) begin
                wdata_reg <= bus_wdata;
            end
            if (take_wr && to_auto) begin
                auto_shadow_reg <= WDATA[crcfc_pkg::AUTO_ENABLE_BIT];
            end
            wr_reg <= take_wr;
            rd_reg <= take_rd;
            rd_wait_reg <= rd_reg;
            rd_valid_reg <= rd_wait_reg;
            if (rd_wait_reg) begin
                rdata_reg <= SFR.rdata;
            end
            guard_reg <= guard_next;
            stall_reg <= SFR.hold || (guard_next != 2'h0);
        end
    end

    assign SFR.addr = addr_reg;
    assign SFR.wdata = wdata_reg;
    assign SFR.wr = wr_reg;
    assign SFR.rd = rd_reg;
    assign RDATA = rdata_reg;
    assign RD_VALID = rd_valid_reg;
    assign STALL = stall_reg;

endmodule : crcfc_host

// [tb/crcfc_checker.sv]
`timescale 1ns/10ps
module crcfc_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register bus
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic hold,
    // Code fetch port
    input wire logic [15:0] CODE_ADDR,
    input wire logic CODE_RD
);
    logic en_reg;
    logic [7:0] start_reg;
    logic [7:0] count_reg;
    logic [7:0] flip_reg;
    logic [15:0] last_reg;
    logic [16:0] run_reg;
    // Accesses during a run are ignored, so shadows skip them too
    wire wr_ok = wr && !hold;
    wire rd_ok = rd && !hold;
    wire launch = wr_ok && addr == 8'hce && en_reg && count_reg != 8'h00;
    wire [7:0] mirror = {flip_reg[0], flip_reg[1], flip_reg[2], flip_reg[3],
        flip_reg[4], flip_reg[5], flip_reg[6], flip_reg[7]};
    // Two cycles per fetched byte, 256 bytes per block
    wire [16:0] run_len = {count_reg, 9'h000};
    wire [15:0] end_addr = {start_reg + count_reg, 8'h00} - 16'h0001;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            en_reg <= 1'b0;
            start_reg <= 8'h00;
            count_reg <= 8'h00;
            flip_reg <= 8'h00;
            last_reg <= 16'h0000;
            run_reg <= 17'h00000;
        end else begin
            if (wr_ok && addr == 8'h86) en_reg <= wdata[7];
            if (wr_ok && addr == 8'hd2) start_reg <= wdata;
            if (wr_ok && addr == 8'hd3) count_reg <= wdata;
            if (wr_ok && addr == 8'hcf) flip_reg <= wdata;
            if (CODE_RD) last_reg <= CODE_ADDR;
            run_reg <= hold ? run_reg + 17'h00001 : 17'h00000;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence launch_s;
        launch;
    endsequence
    sequence fetch_pair_s;
        CODE_RD && hold ##2 CODE_RD;
    endsequence
    sequence run_end_s;
        $fell(hold);
    endsequence

    a_launch_holds: assert property (launch_s |=> hold && CODE_RD)
        else $error("run did not start after launch");
    a_hold_cause: assert property ($rose(hold) |-> $past(launch))
        else $error("hold rose without launch");
    a_start_addr: assert property (launch_s |=>
        CODE_ADDR == {start_reg, 8'h00})
        else $error("first fetch address wrong");
    a_fetch_order: assert property (fetch_pair_s |->
        CODE_ADDR == $past(CODE_ADDR, 2) + 16'h0001)
        else $error("fetch not ascending");
    a_last_fetch: assert property (run_end_s |-> last_reg == end_addr)
        else $error("last fetch address wrong");
    a_run_length: assert property (run_end_s |->
        run_reg >= run_len && run_reg <= run_len + 17'h00002)
        else $error("run length wrong");
    a_no_overrun: assert property (hold |->
        run_reg <= run_len + 17'h00002)
        else $error("run too long");
    a_flip_mirror: assert property (rd_ok && addr == 8'hcf |=>
        rdata == mirror)
        else $error("bit reverse wrong");
    a_done_reads: assert property (rd_ok && addr == 8'h86 |=>
        rdata == {en_reg, 1'b1, 6'h00})
        else $error("auto control read wrong");
    a_ctrl_reserved: assert property (rd_ok && addr == 8'hce |=>
        rdata[7:4] == 4'h1 && !rdata[3] && !rdata[1])
        else $error("control read wrong");
    a_read_window: assert property (rdata != 8'h00 |-> $past(rd))
        else $error("read data outside window");
endmodule : crcfc_checker

// [tb/tb_crc16_engine_flash_check.sv]
`timescale 1ns/10ps
module tb_crc16_engine_flash_check;
    logic CLK, RD_VALID, STALL, CODE_RD;
    logic RESET = 1'b1, WR = 1'b0, RD = 1'b0;
    logic ptr = 1'b0, sel = 1'b0, en = 1'b0;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, CODE_DATA = 8'h00, RDATA;
    logic [7:0] st = 8'h00, cnt = 8'h00, flip = 8'h00, din = 8'h00;
    logic [15:0] CODE_ADDR, acc = 16'h0000;
    logic [7:0] exp_q[$];
    logic [7:0] regs[8] = '{8'h86, 8'hce, 8'hcf, 8'hd2, 8'hd3, 8'hdd,
        8'hde, 8'h00};
    int mismatches = 0, checks = 0, cycles = 0, seed = 92107, n;

    crcfc_sfr_if crcfc_sfr_if_inst ();
    wire dev_hold = crcfc_sfr_if_inst.hold;
    crcfc_host crcfc_host_inst (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RD_VALID(RD_VALID),
        .STALL(STALL), .SFR(crcfc_sfr_if_inst.host));
    crcfc_device crcfc_device_inst (.CLK(CLK), .RESET(RESET),
        .SFR(crcfc_sfr_if_inst.dev), .CODE_ADDR(CODE_ADDR), .CODE_RD(CODE_RD),
        .CODE_DATA(CODE_DATA));
    crcfc_checker crcfc_checker_inst (.CLK(CLK), .RESET(RESET),
        .addr(crcfc_sfr_if_inst.addr), .wdata(crcfc_sfr_if_inst.wdata),
        .wr(crcfc_sfr_if_inst.wr), .rd(crcfc_sfr_if_inst.rd),
        .rdata(crcfc_sfr_if_inst.rdata), .hold(crcfc_sfr_if_inst.hold),
        .CODE_ADDR(CODE_ADDR), .CODE_RD(CODE_RD));

    function automatic logic [15:0] fold(input logic [15:0] a,
        input logic [7:0] b);
        logic [15:0] r;
        r = a ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ crcfc_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : fold

    function automatic logic [7:0] code_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : code_byte

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Code memory; an idle data line inverts its last value every cycle
    always @(posedge CLK) begin
        CODE_DATA <= CODE_RD ? code_byte(CODE_ADDR) : ~CODE_DATA;
    end

    task automatic chk(input logic ok, input string m);
        checks++;
        if (!ok) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // One strobe cycle, then one idle cycle so no strobe is set twice at once
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= w;
        RD <= !w;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b0;
        @(posedge CLK);
    endtask : bus

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        case (a)
            8'hce: begin
                if (d[3]) acc = d[2] ? 16'hffff : 16'h0000;
                sel = d[2];
                ptr = d[0];
            end
            8'hdd: begin
                din = d;
                acc = fold(acc, d);
            end
            8'hde: begin
                if (ptr) acc[15:8] = d;
                else acc[7:0] = d;
            end
            8'h86: en = d[7];
            8'hd2: st = d;
            8'hd3: cnt = d;
            8'hcf: flip = d;
            default: ;
        endcase
        if (a == 8'hce && en) begin
            for (int i = 0; i < 256 * cnt; i++) begin
                acc = fold(acc,
                    code_byte({st, 8'h00} + 16'(i)));
            end
            // The guard stalls the core even when the count is zero
            repeat (2) @(negedge CLK);
            chk(STALL === 1'b1, "launch guard");
            n = 0;
            while (dev_hold !== 1'b1 && n < 8) begin
                @(negedge CLK);
                n++;
            end
            chk((dev_hold === 1'b1) == (cnt != 8'h00), "run start");
            // No request goes out while the core is held
            while (STALL === 1'b1 && n < 2000) begin
                @(negedge CLK);
                n++;
            end
            chk(STALL === 1'b0, "stall stuck");
            @(posedge CLK);
        end
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        logic [7:0] x;
        case (a)
            8'hce: x = {4'h1, 1'b0, sel, 1'b0, ptr};
            8'hde: begin
                x = ptr ? acc[15:8] : acc[7:0];
                ptr = !ptr;
            end
            8'hcf: x = {<<{flip}};
            8'h86: x = {en, 1'b1, 6'h00};
            8'hd2: x = st;
            8'hd3: x = cnt;
            8'hdd: x = din;
            default: x = 8'h00;
        endcase
        exp_q.push_back(x);
        bus(1'b0, a, 8'h00);
    endtask : rd_reg

    task automatic auto_run(input logic [7:0] s, input logic [7:0] c,
        input logic [7:0] k);
        wr_reg(8'hd2, s);
        wr_reg(8'h86, 8'h80);
        wr_reg(8'hd3, c);
        wr_reg(8'hce, k);
        rd_reg(8'h86);
        wr_reg(8'h86, 8'h00);
        wr_reg(8'hce, 8'h10);
        repeat (2) rd_reg(8'hde);
    endtask : auto_run

    always @(negedge CLK) begin
        cycles++;
        if (RD_VALID === 1'b1) begin
            chk(exp_q.size() != 0 && RDATA === exp_q[0], "read");
            if (exp_q.size() != 0) exp_q.delete(0);
        end
        if (cycles > 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        foreach (regs[i]) rd_reg(regs[i]);
        wr_reg(8'hce, 8'h18);
        wr_reg(8'hdd, 8'h63);
        wr_reg(8'hce, 8'h10);
        repeat (2) rd_reg(8'hde);
        for (int s = 0; s < 2; s++) begin
            wr_reg(8'hce, s[0] ? 8'h1c : 8'h18);
            repeat (5) wr_reg(8'hdd, 8'($random(seed)));
            wr_reg(8'hce, 8'h10);
            repeat (3) rd_reg(8'hde);
            rd_reg(8'hce);
            rd_reg(8'hdd);
        end
        wr_reg(8'hce, 8'h11);
        wr_reg(8'hde, 8'($random(seed)));
        rd_reg(8'hde);
        wr_reg(8'hde, 8'($random(seed)));
        rd_reg(8'hde);
        wr_reg(8'hdd, 8'($random(seed)));
        repeat (2) rd_reg(8'hde);
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'hcf, i == 0 ? 8'hc0 : 8'($random(seed)));
            rd_reg(8'hcf);
        end
        wr_reg(8'hce, 8'h18);
        auto_run(8'($random(seed)) & 8'h0f, 8'h00, 8'h10);
        auto_run(8'($random(seed)) & 8'h0f, 8'h01, 8'h10);
        auto_run(8'hff, 8'h02, 8'h1c);
        repeat (8) @(negedge CLK);
        chk(exp_q.size() == 0, "reads missing");
        print_verdict();
    end
endmodule : tb_crc16_engine_flash_check
